/* hdl/fsw_sequencer.sv */
// Purpose: flash self-write sequencer with Avalon-MM register slave
// Assumes: core writes registers over the bus; flash array sits outside
// Notes: flash row writes/erases are issued as one-cycle commands
// What this block does
// - only 55h then AAh to unlock port, then write-start, arms an operation.
// - broken unlock sequence loads no latch and starts no erase or program.
// - write-start forces two no-operation cycles on the core.
// - erase or program stalls the core for about 2 ms, then resumes.
// - clocks and peripherals keep running during the stall; not sleep.
// - latch load forces two no-op cycles then continues without stall.
// - after erase the core resumes at the third instruction after write-start.
// - erase uses any address in the row with erase select and enable set.
// - erase always covers one full row, never a smaller unit.
// - programming never erases first; it writes only latched data.
// - upper ten address bits pick the row, low four bits pick the latch.
// - one programming operation stays inside the addressed row.
// - every write or erase completion resets all latches to 3FFFh.
// - latch-only select set: unlock copies data pair into addressed latch.
// - latch-only select clear: load final word, then program whole row.
// - at most one latch-set of words per program; unloaded latches stay blank.
// - erase, latch load, main program and user-id program all need unlock.
// - read-start and write-start are set-only; hardware clears them.
// - write enable clear after reset; abort flag set when reset cuts a write.
// - unlock port is write-only and reads as zero.
`timescale 1ns/1ps
module fsw_sequencer #(
	parameter int OP_CYCLES = fsw_pkg::OP_CYCLES
)(
	input wire logic clk,
	input wire logic srst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic core_force_nop,
	output logic core_stall,
	output logic flash_erase_row,
	output logic flash_program_row,
	output logic flash_cfg_space,
	output logic [fsw_pkg::ROW_W-1:0] flash_row,
	output logic [fsw_pkg::LATCH_COUNT*14-1:0] flash_row_data
);
	typedef struct packed {
		fsw_pkg::fsw_state_t st;
		fsw_pkg::fsw_op_t op;
		logic [22:0] cnt;
		logic [7:0] addr_lo;
		logic [6:0] addr_hi;
		logic [7:0] dat_lo;
		logic [5:0] dat_hi;
		logic rd_start;
		logic wr_start;
		logic wr_en;
		logic wr_abort;
		logic erase_sel;
		logic latch_only;
		logic cfg_sel;
		logic [fsw_pkg::LATCH_COUNT*14-1:0] latches;
		logic [31:0] rdata;
		logic ack;
		logic force_nop;
		logic stall;
		logic erase_cmd;
		logic prog_cmd;
		logic op_cfg;
		logic [fsw_pkg::ROW_W-1:0] row;
	} fsw_regs_t;

	fsw_regs_t q_r;
	fsw_regs_t q_nxt;
	logic abort_seen_r;
	logic wr_acc;
	logic rd_acc;

	function automatic logic [fsw_pkg::LATCH_COUNT*14-1:0] blank_all();
		blank_all = {fsw_pkg::LATCH_COUNT{fsw_pkg::BLANK_WORD}};
	endfunction : blank_all

	assign wr_acc = avs_write && !q_r.ack;
	assign rd_acc = avs_read && !q_r.ack;

	always_comb
	begin
		q_nxt = q_r;
		q_nxt.ack = 1'b0;
		q_nxt.erase_cmd = 1'b0;
		q_nxt.prog_cmd = 1'b0;
		// read-start lasts one cycle; a new set in that cycle wins
		q_nxt.rd_start = 1'b0;
		// one-cycle wait then ack: every access takes exactly two edges
		if (avs_read || avs_write)
		begin
			q_nxt.ack = !q_r.ack;
		end
		if (rd_acc)
		begin
			unique case (avs_address)
				fsw_pkg::OFS_CONTROL: q_nxt.rdata = {25'h0, q_r.cfg_sel, q_r.latch_only, q_r.erase_sel,
					q_r.wr_abort, q_r.wr_en, q_r.wr_start, q_r.rd_start};
				fsw_pkg::OFS_UNLOCK: q_nxt.rdata = 32'h0000_0000;
				fsw_pkg::OFS_ADDR_LOW: q_nxt.rdata = {24'h000000, q_r.addr_lo};
				fsw_pkg::OFS_ADDR_HIGH: q_nxt.rdata = {25'h0, q_r.addr_hi};
				fsw_pkg::OFS_DATA_LOW: q_nxt.rdata = {24'h0, q_r.dat_lo};
				fsw_pkg::OFS_DATA_HIGH: q_nxt.rdata = {26'h0, q_r.dat_hi};
				fsw_pkg::OFS_STATUS: q_nxt.rdata = {27'h0, q_r.st};
				default: q_nxt.rdata = fsw_pkg::RD_UNMAPPED;
			endcase
		end
		if (wr_acc)
		begin
			unique case (avs_address)
				fsw_pkg::OFS_CONTROL:
				begin
					q_nxt.rd_start = avs_writedata[fsw_pkg::BIT_READ_START];
					q_nxt.wr_en = avs_writedata[fsw_pkg::BIT_WRITE_ENABLE];
					q_nxt.wr_abort = avs_writedata[fsw_pkg::BIT_WRITE_ABORT];
					q_nxt.erase_sel = avs_writedata[fsw_pkg::BIT_ERASE_SELECT];
					q_nxt.latch_only = avs_writedata[fsw_pkg::BIT_LATCH_ONLY];
					q_nxt.cfg_sel = avs_writedata[fsw_pkg::BIT_CONFIG_SPACE];
					if (avs_writedata[fsw_pkg::BIT_WRITE_START] && q_r.st == fsw_pkg::ST_ARMED)
					begin
						q_nxt.wr_start = 1'b1;
						q_nxt.st = fsw_pkg::ST_NOPS;
						q_nxt.cnt = 23'(fsw_pkg::NOP_CYCLES - 1);
						q_nxt.force_nop = 1'b1;
						if (!avs_writedata[fsw_pkg::BIT_WRITE_ENABLE])
							q_nxt.op = fsw_pkg::OP_NONE;
						else if (avs_writedata[fsw_pkg::BIT_ERASE_SELECT])
							q_nxt.op = fsw_pkg::OP_ERASE;
						else if (avs_writedata[fsw_pkg::BIT_LATCH_ONLY])
							q_nxt.op = fsw_pkg::OP_LATCH;
						else
							q_nxt.op = fsw_pkg::OP_PROGRAM;
					end
					else if (q_r.st != fsw_pkg::ST_NOPS && q_r.st != fsw_pkg::ST_BUSY)
					begin
						q_nxt.st = fsw_pkg::ST_IDLE;
					end
				end
				fsw_pkg::OFS_UNLOCK:
				begin
					if (q_r.st != fsw_pkg::ST_NOPS && q_r.st != fsw_pkg::ST_BUSY)
					begin
						if (avs_writedata[7:0] == fsw_pkg::UNLOCK_FIRST)
							q_nxt.st = fsw_pkg::ST_GOT55;
						else if (avs_writedata[7:0] == fsw_pkg::UNLOCK_SECOND && q_r.st == fsw_pkg::ST_GOT55)
							q_nxt.st = fsw_pkg::ST_ARMED;
						else
							q_nxt.st = fsw_pkg::ST_IDLE;
					end
				end
				fsw_pkg::OFS_ADDR_LOW: q_nxt.addr_lo = avs_writedata[7:0];
				fsw_pkg::OFS_ADDR_HIGH: q_nxt.addr_hi = avs_writedata[6:0];
				fsw_pkg::OFS_DATA_LOW: q_nxt.dat_lo = avs_writedata[7:0];
				fsw_pkg::OFS_DATA_HIGH: q_nxt.dat_hi = avs_writedata[5:0];
				default:
				begin
					// any other write breaks the sequence
					if (q_r.st == fsw_pkg::ST_GOT55 || q_r.st == fsw_pkg::ST_ARMED)
						q_nxt.st = fsw_pkg::ST_IDLE;
				end
			endcase
		end
		// reset cut a write: flag latched at release
		if (abort_seen_r)
			q_nxt.wr_abort = 1'b1;
		unique case (q_r.st)
			fsw_pkg::ST_NOPS:
			begin
				if (q_r.cnt != 23'h000000)
					q_nxt.cnt = q_r.cnt - 23'h000001;
				else
				begin
					q_nxt.force_nop = 1'b0;
					q_nxt.row = {q_r.addr_hi, q_r.addr_lo[7:5]};
					q_nxt.op_cfg = q_r.cfg_sel;
					unique case (q_r.op)
						fsw_pkg::OP_LATCH:
						begin
							// copy data pair into the latch picked by the low four bits of addr_lo
							q_nxt.latches[q_r.addr_lo[fsw_pkg::LATCH_IDX_W-1:0]*14 +: 14] = {q_r.dat_hi, q_r.dat_lo};
							q_nxt.wr_start = 1'b0;
							q_nxt.st = fsw_pkg::ST_IDLE;
						end
						fsw_pkg::OP_ERASE, fsw_pkg::OP_PROGRAM:
						begin
							if (q_r.op == fsw_pkg::OP_PROGRAM)
								q_nxt.latches[q_r.addr_lo[fsw_pkg::LATCH_IDX_W-1:0]*14 +: 14] = {q_r.dat_hi, q_r.dat_lo};
							q_nxt.stall = 1'b1;
							q_nxt.cnt = 23'(OP_CYCLES - 1);
							q_nxt.st = fsw_pkg::ST_BUSY;
						end
						default:
						begin
							q_nxt.wr_start = 1'b0;
							q_nxt.st = fsw_pkg::ST_IDLE;
						end
					endcase
				end
			end
			fsw_pkg::ST_BUSY:
			begin
				if (q_r.cnt != 23'h000000)
					q_nxt.cnt = q_r.cnt - 23'h000001;
				else
				begin
					q_nxt.erase_cmd = (q_r.op == fsw_pkg::OP_ERASE);
					q_nxt.prog_cmd = (q_r.op == fsw_pkg::OP_PROGRAM);
					// release stall; the two no-ops ran before the stall, core resumes now
					q_nxt.stall = 1'b0;
					q_nxt.wr_start = 1'b0;
					q_nxt.st = fsw_pkg::ST_IDLE;
				end
			end
			default:
			begin
			end
		endcase
		if (q_r.erase_cmd || q_r.prog_cmd)
			q_nxt.latches = blank_all();
	end

	always_ff @(posedge clk)
	begin
		// remember a mid-operation reset for as long as it is held, not just its first edge
		abort_seen_r <= srst && (abort_seen_r || q_r.st == fsw_pkg::ST_BUSY || q_r.st == fsw_pkg::ST_NOPS);
		if (srst)
		begin
			q_r <= '0;
			q_r.st <= fsw_pkg::ST_IDLE;
			q_r.latches <= {fsw_pkg::LATCH_COUNT{fsw_pkg::BLANK_WORD}};
		end
		else
			q_r <= q_nxt;
	end

	// only the core is stalled; this block and the bus keep running
	assign avs_readdata = q_r.rdata;
	assign avs_waitrequest = !q_r.ack;
	assign core_force_nop = q_r.force_nop;
	assign core_stall = q_r.stall;
	assign flash_erase_row = q_r.erase_cmd;
	assign flash_program_row = q_r.prog_cmd;
	assign flash_cfg_space = q_r.op_cfg;
	assign flash_row = q_r.row;
	assign flash_row_data = q_r.latches;

	property p_unlock_needs_55;
		@(posedge clk) disable iff (srst)
		$rose(q_r.st == fsw_pkg::ST_ARMED) |-> $past(q_r.st) == fsw_pkg::ST_GOT55;
	endproperty
	a_unlock_needs_55: assert property (p_unlock_needs_55) else $error("armed without 55h");
	sequence s_two_nops;
		core_force_nop [*2] ##1 !core_force_nop;
	endsequence
	property p_nop_two;
		@(posedge clk) disable iff (srst)
		$rose(core_force_nop) |-> s_two_nops;
	endproperty
	a_nop_two: assert property (p_nop_two) else $error("forced no-op count wrong");
	property p_stall_len;
		@(posedge clk) disable iff (srst)
		$rose(core_stall) |-> core_stall [*8];
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall too short");
	property p_latch_no_stall;
		@(posedge clk) disable iff (srst)
		(q_r.st == fsw_pkg::ST_NOPS && q_r.op == fsw_pkg::OP_LATCH) |=> !core_stall;
	endproperty
	a_latch_no_stall: assert property (p_latch_no_stall) else $error("latch load stalled");
	property p_cmd_after_stall;
		@(posedge clk) disable iff (srst)
		(flash_erase_row || flash_program_row) |-> $past(core_stall) && !core_stall;
	endproperty
	a_cmd_after_stall: assert property (p_cmd_after_stall) else $error("command without stall");
	property p_blank;
		@(posedge clk) disable iff (srst)
		(flash_erase_row || flash_program_row) |=> flash_row_data == {fsw_pkg::LATCH_COUNT{fsw_pkg::BLANK_WORD}};
	endproperty
	a_blank: assert property (p_blank) else $error("latches not blanked");
	property p_wstart_hold;
		@(posedge clk) disable iff (srst)
		core_stall |-> q_r.wr_start;
	endproperty
	a_wstart_hold: assert property (p_wstart_hold) else $error("write-start cleared early");
	property p_no_en_no_op;
		@(posedge clk) disable iff (srst)
		(q_r.st == fsw_pkg::ST_NOPS && q_r.op == fsw_pkg::OP_NONE) |-> ##[1:3] q_r.st == fsw_pkg::ST_IDLE && !core_stall;
	endproperty
	a_no_en_no_op: assert property (p_no_en_no_op) else $error("operation without enable");
endmodule : fsw_sequencer

/* pkg/fsw_pkg.sv */
// Purpose: constants and types for the flash self-write sequencer
// Assumes: 40 MHz clk, Avalon-MM register slave with 32-bit data
// Notes: register offsets are byte addresses, one word per register
package fsw_pkg;
	localparam int CLK_MHZ = 40;
	localparam int OP_TIME_US = 2000;
	localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
	localparam int POR_WAIT_US = 100;
	localparam int POR_WAIT_CYCLES = POR_WAIT_US * CLK_MHZ;
	localparam int NOP_CYCLES = 2;
	localparam logic [7:0] UNLOCK_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
	localparam logic [13:0] BLANK_WORD = 14'h3FFF;
	localparam int LATCH_COUNT = 16;
	localparam int LATCH_IDX_W = 4;
	localparam int ROW_W = 10;
	localparam int ADDR_W = 15;
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_UNLOCK = 5'h04;
	localparam logic [4:0] OFS_ADDR_LOW = 5'h08;
	localparam logic [4:0] OFS_ADDR_HIGH = 5'h0C;
	localparam logic [4:0] OFS_DATA_LOW = 5'h10;
	localparam logic [4:0] OFS_DATA_HIGH = 5'h14;
	localparam logic [4:0] OFS_STATUS = 5'h18;
	// control register bit positions
	localparam int BIT_READ_START = 0;
	localparam int BIT_WRITE_START = 1;
	localparam int BIT_WRITE_ENABLE = 2;
	localparam int BIT_WRITE_ABORT = 3;
	localparam int BIT_ERASE_SELECT = 4;
	localparam int BIT_LATCH_ONLY = 5;
	localparam int BIT_CONFIG_SPACE = 6;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_GOT55 = 5'b00010,
		ST_ARMED = 5'b00100,
		ST_NOPS = 5'b01000,
		ST_BUSY = 5'b10000
	} fsw_state_t;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ERASE = 2'b01,
		OP_LATCH = 2'b10,
		OP_PROGRAM = 2'b11
	} fsw_op_t;
endpackage : fsw_pkg

/* sim/fsw_core_model.sv */
// Purpose: core-side model that counts forced no-ops and stall cycles
// Assumes: core retires one instruction a cycle when not held
// Notes: por_done gates the first unlock attempt
`timescale 1ns/1ps
module fsw_core_model #(
	parameter int POR_WAIT = fsw_pkg::POR_WAIT_CYCLES
)(
	input wire logic clk,
	input wire logic srst,
	input wire logic core_force_nop,
	input wire logic core_stall,
	output logic por_done,
	output logic [15:0] nop_cnt,
	output logic [15:0] stall_cnt
);
	logic [15:0] por_cnt_r;
	assign por_done = (por_cnt_r >= 16'(POR_WAIT));
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			por_cnt_r <= 16'h0000;
			nop_cnt <= 16'h0000;
			stall_cnt <= 16'h0000;
		end
		else
		begin
			if (!por_done)
				por_cnt_r <= por_cnt_r + 16'h0001;
			if (core_force_nop === 1'b1)
				nop_cnt <= nop_cnt + 16'h0001;
			// clock keeps running, so stall cycles are countable
			if (core_stall === 1'b1)
				stall_cnt <= stall_cnt + 16'h0001;
		end
	end
endmodule : fsw_core_model

/* sim/fsw_sequencer_tb.sv */
// Purpose: self-checking bench for the flash self-write sequencer
// Assumes: short operation time so runs stay brief
// Notes: expected latch data is built from the writes made here
`timescale 1ns/1ps
module fsw_sequencer_tb;
	localparam int OPC = 20;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, core_force_nop, core_stall, flash_erase_row, flash_program_row, flash_cfg_space, por_done;
	logic pulse_cfg;
	logic [9:0] flash_row, pulse_row;
	logic [223:0] flash_row_data, pulse_data;
	logic [15:0] nop_cnt, stall_cnt, n0, s0;
	int miscompares = 0;
	int total_checks = 0;
	int prog_seen = 0;
	int erase_seen = 0;
	int i;
	fsw_sequencer #(.OP_CYCLES(OPC)) i_fsw_sequencer (.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .core_force_nop(core_force_nop), .core_stall(core_stall),
		.flash_erase_row(flash_erase_row), .flash_program_row(flash_program_row),
		.flash_cfg_space(flash_cfg_space), .flash_row(flash_row), .flash_row_data(flash_row_data));
	fsw_core_model i_fsw_core_model (.clk(clk), .srst(srst), .core_force_nop(core_force_nop),
		.core_stall(core_stall), .por_done(por_done), .nop_cnt(nop_cnt), .stall_cnt(stall_cnt));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	// snapshot row and latches at the one-cycle command pulse
	always @(posedge clk)
	begin
		if (flash_program_row === 1'b1)
			prog_seen++;
		if (flash_erase_row === 1'b1)
			erase_seen++;
		if (flash_program_row === 1'b1 || flash_erase_row === 1'b1)
		begin
			pulse_row <= flash_row;
			pulse_data <= flash_row_data;
			pulse_cfg <= flash_cfg_space;
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_latch(input logic [223:0] v, input int idx, input logic [13:0] exp);
		chk($sformatf("latch %0d", idx), {18'h0, exp}, {18'h0, v[idx*14+:14]});
	endtask : chk_latch
	// request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n == 50)
		begin
			miscompares++;
			final_report();
		end
	endtask : bus
	task automatic wait_idle;
		int n;
		for (n = 0; n < 80; n++)
		begin
			bus(1'b0, fsw_pkg::OFS_STATUS, 32'h0);
			if (rd === {27'h0, fsw_pkg::ST_IDLE})
				break;
		end
		if (n == 80)
		begin
			miscompares++;
			final_report();
		end
	endtask : wait_idle
	task automatic set_word(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] dat);
		bus(1'b1, fsw_pkg::OFS_ADDR_HIGH, {24'h0, hi});
		bus(1'b1, fsw_pkg::OFS_ADDR_LOW, {24'h0, lo});
		bus(1'b1, fsw_pkg::OFS_DATA_LOW, {24'h0, dat[7:0]});
		bus(1'b1, fsw_pkg::OFS_DATA_HIGH, {24'h0, dat[15:8]});
	endtask : set_word
	// the bench has no interrupts, so no sequence is ever broken by one
	task automatic unlock(input logic [31:0] ctrl, input logic [7:0] second);
		n0 = nop_cnt;
		s0 = stall_cnt;
		bus(1'b1, fsw_pkg::OFS_CONTROL, ctrl);
		bus(1'b1, fsw_pkg::OFS_UNLOCK, {24'h0, fsw_pkg::UNLOCK_FIRST});
		bus(1'b1, fsw_pkg::OFS_UNLOCK, {24'h0, second});
		bus(1'b1, fsw_pkg::OFS_CONTROL, ctrl | 32'h2);
	endtask : unlock
	task automatic start(input logic [31:0] ctrl, input logic [7:0] second);
		unlock(ctrl, second);
		wait_idle();
	endtask : start
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 16; i++)
			chk_latch(flash_row_data, i, fsw_pkg::BLANK_WORD);
		bus(1'b0, fsw_pkg::OFS_CONTROL, 32'h0);
		chk("write enable", 32'h0, rd & 32'h4);
		bus(1'b0, fsw_pkg::OFS_UNLOCK, 32'h0);
		chk("unlock read", 32'h0, rd);
		bus(1'b0, 5'h1C, 32'h0);
		chk("unmapped read", 32'h0, rd);
		$display("test reset done");
		// no unlock before the power-on wait is over
		for (i = 0; i < 5000 && por_done !== 1'b1; i++)
			@(posedge clk);
		if (por_done !== 1'b1)
		begin
			miscompares++;
			final_report();
		end
		// row write order: address and data, latch-only set, unlock
		set_word(8'h01, 8'h23, 16'h1234);
		start(32'h20, fsw_pkg::UNLOCK_SECOND);
		chk_latch(flash_row_data, 3, fsw_pkg::BLANK_WORD);
		start(32'h24, 8'h33);
		chk_latch(flash_row_data, 3, fsw_pkg::BLANK_WORD);
		chk("stall no unlock", 32'h0, 32'(stall_cnt - s0));
		$display("test refused unlock done");
		start(32'h24, fsw_pkg::UNLOCK_SECOND);
		chk_latch(flash_row_data, 3, 14'h1234);
		chk_latch(flash_row_data, 4, fsw_pkg::BLANK_WORD);
		chk("latch nops", 32'd2, 32'(nop_cnt - n0));
		chk("latch stall", 32'h0, 32'(stall_cnt - s0));
		bus(1'b0, fsw_pkg::OFS_CONTROL, 32'h0);
		chk("write start", 32'h0, rd & 32'h2);
		$display("test latch load done");
		// this row was never written, so no erase is needed first
		set_word(8'h01, 8'h24, 16'h0ABC);
		start(32'h04, fsw_pkg::UNLOCK_SECOND);
		chk("program pulses", 32'd1, 32'(prog_seen));
		chk("program row", 32'h009, {22'h0, pulse_row});
		chk_latch(pulse_data, 3, 14'h1234);
		chk_latch(pulse_data, 4, 14'h0ABC);
		chk_latch(pulse_data, 0, fsw_pkg::BLANK_WORD);
		chk("program stall", OPC, 32'(stall_cnt - s0));
		chk_latch(flash_row_data, 3, fsw_pkg::BLANK_WORD);
		$display("test program done");
		set_word(8'h02, 8'h4F, 16'h0000);
		start(32'h14, fsw_pkg::UNLOCK_SECOND);
		chk("erase pulses", 32'd1, 32'(erase_seen));
		chk("erase no program", 32'd1, 32'(prog_seen));
		chk("erase row", 32'h012, {22'h0, pulse_row});
		chk("erase nops", 32'd2, 32'(nop_cnt - n0));
		chk("erase stall", OPC, 32'(stall_cnt - s0));
		chk_latch(flash_row_data, 4, fsw_pkg::BLANK_WORD);
		chk("erase config space", 32'h0, {31'h0, pulse_cfg});
		$display("test erase done");
		set_word(8'h00, 8'h00, 16'h0123);
		start(32'h44, fsw_pkg::UNLOCK_SECOND);
		chk("config program pulses", 32'd2, 32'(prog_seen));
		chk("config space at pulse", 32'h1, {31'h0, pulse_cfg});
		chk("config program stall", OPC, 32'(stall_cnt - s0));
		$display("test config program done");
		// reset lands while the forced no-ops of an erase run
		unlock(32'h14, fsw_pkg::UNLOCK_SECOND);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		bus(1'b0, fsw_pkg::OFS_CONTROL, 32'h0);
		chk("write abort", 32'h8, rd & 32'h8);
		chk("enable after reset", 32'h0, rd & 32'h4);
		chk("stall after reset", 32'h0, {31'h0, core_stall});
		chk("erase after reset", 32'd1, 32'(erase_seen));
		$display("test reset abort done");
		final_report();
	end
endmodule : fsw_sequencer_tb
